/* File: iec_pkg.sv */
// Package for the internal event comparator: register map, type codes, widths.
// Assumes a single 50 MHz clock domain and APB register access.
package iec_pkg;
	localparam int unsigned CLOCK_HZ = 50_000_000;
	localparam int NUM_EVT = 5;
	localparam int VAL_W = 16;
	localparam logic [4:0] TYPE_DEV_BAND_FINAL = 5'h09;
	localparam logic [4:0] TYPE_SP_HIGH = 5'h0a;
	localparam logic [4:0] TYPE_SP_LOW = 5'h0b;
	localparam logic [4:0] TYPE_SP_BAND = 5'h0c;
	localparam logic [4:0] TYPE_MV_HIGH = 5'h0d;
	localparam logic [4:0] TYPE_MV_LOW = 5'h0e;
	localparam logic [4:0] TYPE_MV_BAND = 5'h0f;
	localparam logic [4:0] TYPE_HTR1_BAND = 5'h10;
	localparam logic [4:0] TYPE_HTR1_SHORT = 5'h11;
	localparam logic [4:0] TYPE_HTR2_BAND = 5'h12;
	localparam logic [4:0] TYPE_HTR2_SHORT = 5'h13;
	// Global registers
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_MASK = 12'h004;
	localparam logic [11:0] ADDR_EVENTS = 12'h008;
	// Per-evaluator block: base + 16*n
	localparam logic [11:0] ADDR_EVT_BASE = 12'h100;
	localparam int EVT_STRIDE_SH = 4;
	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_MAIN = 4'h4;
	localparam logic [3:0] OFS_SUB = 4'h8;
	localparam logic [3:0] OFS_HYS = 4'hc;
	// Config word fields
	localparam int CFG_TYPE_LSB = 0;
	localparam int CFG_REV_BIT = 8;
	localparam logic [4:0] RST_TYPE = 5'h00;
	localparam logic [VAL_W-1:0] RST_VALUE = 16'h0000;
	localparam logic [4:0] RST_MASK = 5'h00;
endpackage

/* File: iec_compare.sv */
// One hysteresis comparator: high limit, low limit or band, with direct/reverse sense.
// Assumes signed values and a one-cycle registered result; enable gates output off.
`timescale 1ns/1ns
module iec_compare (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_enable,
	input wire logic [1:0] i_shape,
	input wire logic i_reverse,
	input wire logic signed [15:0] i_value,
	input wire logic signed [15:0] i_main,
	input wire logic signed [15:0] i_sub,
	input wire logic signed [15:0] i_hys,
	output logic o_event
);
	// Shape: 0 high limit, 1 low limit, 2 band (on outside), 3 off
	typedef struct packed {
		logic raw;
		logic evt;
	} iec_cmp_state_t;
	iec_cmp_state_t state;
	iec_cmp_state_t next_state;
	logic signed [17:0] lo;
	logic signed [17:0] hi;
	logic signed [17:0] v;
	always_comb begin
		next_state = state;
		v = 18'(i_value);
		if (i_shape == 2'd2 && i_main > i_sub) begin
			lo = 18'(i_sub);
			hi = 18'(i_main);
		end else begin
			lo = 18'(i_main);
			hi = 18'(i_sub);
		end
		// on at limit, off past hysteresis
		unique case (i_shape)
			2'd0: next_state.raw = state.raw ? (v >= lo - 18'(i_hys)) : (v >= lo);
			2'd1: next_state.raw = state.raw ? (v <= lo + 18'(i_hys)) : (v <= lo);
			2'd2: next_state.raw = state.raw ? (v <= lo + 18'(i_hys) || v >= hi - 18'(i_hys))
				: (v <= lo || v >= hi);
			2'd3: next_state.raw = 1'b0;
		endcase
		if (!i_enable) begin
			next_state.raw = 1'b0;
			next_state.evt = 1'b0;
		end else begin
			next_state.evt = (i_shape == 2'd3) ? 1'b0 : (next_state.raw ^ i_reverse);
		end
		if (i_srst) begin
			next_state = '0;
		end
	end
	always_ff @(posedge i_clock) begin
		state <= next_state;
	end
	assign o_event = state.evt;
	a_disable_off: assert property (@(posedge i_clock) disable iff (i_srst)
		!i_enable |=> !o_event) else $error("event on while disabled");
	a_high_on: assert property (@(posedge i_clock) disable iff (i_srst)
		i_enable && i_shape == 2'd0 && !i_reverse && !i_hys[15] && i_value >= i_main |=> o_event)
		else $error("high limit did not turn on");
endmodule

/* File: iec_settings_mem.sv */
// Settings store: type/sense, main, sub, hysteresis for each evaluator.
// Registered read port; all entries readable in parallel for the comparators.
`timescale 1ns/1ns
module iec_settings_mem (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_we,
	input wire logic [2:0] i_waddr,
	input wire logic [1:0] i_wfield,
	input wire logic [31:0] i_wdata,
	input wire logic [2:0] i_raddr,
	input wire logic [1:0] i_rfield,
	output logic [31:0] o_rdata,
	output logic [iec_pkg::NUM_EVT*5-1:0] o_type,
	output logic [iec_pkg::NUM_EVT-1:0] o_reverse,
	output logic [iec_pkg::NUM_EVT*16-1:0] o_main,
	output logic [iec_pkg::NUM_EVT*16-1:0] o_sub,
	output logic [iec_pkg::NUM_EVT*16-1:0] o_hys
);
	typedef struct packed {
		logic [iec_pkg::NUM_EVT-1:0][4:0] typ;
		logic [iec_pkg::NUM_EVT-1:0] rev;
		logic [iec_pkg::NUM_EVT-1:0][15:0] main;
		logic [iec_pkg::NUM_EVT-1:0][15:0] sub;
		logic [iec_pkg::NUM_EVT-1:0][15:0] event_hysteresis;
		logic [31:0] rdata;
	} iec_mem_state_t;
	iec_mem_state_t state;
	iec_mem_state_t next_state;
	always_comb begin
		next_state = state;
		if (i_we && i_waddr < 3'(iec_pkg::NUM_EVT)) begin
			unique case (i_wfield)
				2'd0: begin
					next_state.typ[i_waddr] = i_wdata[iec_pkg::CFG_TYPE_LSB +: 5];
					next_state.rev[i_waddr] = i_wdata[iec_pkg::CFG_REV_BIT];
				end
				2'd1: next_state.main[i_waddr] = i_wdata[15:0];
				2'd2: next_state.sub[i_waddr] = i_wdata[15:0];
				2'd3: next_state.event_hysteresis[i_waddr] = i_wdata[15:0];
			endcase
		end
		next_state.rdata = 32'h0;
		if (i_raddr < 3'(iec_pkg::NUM_EVT)) begin
			unique case (i_rfield)
				2'd0: next_state.rdata = {23'h0, state.rev[i_raddr], 3'h0, state.typ[i_raddr]};
				2'd1: next_state.rdata = {16'h0, state.main[i_raddr]};
				2'd2: next_state.rdata = {16'h0, state.sub[i_raddr]};
				2'd3: next_state.rdata = {16'h0, state.event_hysteresis[i_raddr]};
			endcase
		end
		if (i_srst) begin
			next_state = '0;
		end
	end
	always_ff @(posedge i_clock) begin
		state <= next_state;
	end
	assign o_type = state.typ;
	assign o_reverse = state.rev;
	assign o_main = state.main;
	assign o_sub = state.sub;
	assign o_hys = state.event_hysteresis;
	assign o_rdata = state.rdata;
endmodule

/* File: iec_top.sv */
// Internal event comparator: five evaluators for type codes 9 to 19, APB registers.
// Assumes process inputs synchronous to i_clock; currents valid when their strobe pulses.
//
// Notes on behaviour
// - Code 9 direct, no ramp: deviation band around present setpoint.
// - Code 9 during ramp: band referenced to final ramp target setpoint.
// - Code 9 reverse: reverse deviation band, final target during ramp.
// - Codes 10-12 compare setpoint against high, low or band limits.
// - Code 16: sensor one reading with heater on, band check.
// - Code 17: sensor one reading with heater off, high limit check.
// - Code 18: band check on sensor two reading with heater on.
// - Code 19: high limit check on sensor two reading with heater off.
// - Codes 16, 17: output off until first sensor one measurement.
// - Codes 18, 19: output off until first sensor two measurement.
// - Band types swap main and sub when main exceeds sub.
// - Heater events detect nothing before the first current measurement.
// - Five independent evaluators, each with own type, settings, sense.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module iec_top (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [15:0] i_process_value,
	input wire logic signed [15:0] i_target_setpoint,
	input wire logic signed [15:0] i_final_setpoint,
	input wire logic i_ramp_active,
	input wire logic signed [15:0] i_manipulated_output,
	input wire logic signed [15:0] i_current_sensor_one,
	input wire logic i_current_sensor_one_valid,
	input wire logic signed [15:0] i_current_sensor_two,
	input wire logic i_current_sensor_two_valid,
	input wire logic i_heater_on,
	output logic [iec_pkg::NUM_EVT-1:0] o_event,
	output logic o_irq
);
	typedef enum logic [1:0] {IEC_IDLE, IEC_WAIT, IEC_DONE} iec_bus_state_t;
	typedef struct packed {
		iec_bus_state_t bus;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [iec_pkg::NUM_EVT-1:0] status;
		logic [iec_pkg::NUM_EVT-1:0] mask;
		logic irq;
		logic [iec_pkg::NUM_EVT-1:0] evt_q;
		logic [15:0] ct1_on;
		logic [15:0] ct1_off;
		logic [15:0] ct2_on;
		logic [15:0] ct2_off;
		logic ct1_seen;
		logic ct2_seen;
	} iec_state_t;
	iec_state_t state;
	iec_state_t next_state;

	logic [iec_pkg::NUM_EVT*5-1:0] cfg_type;
	logic [iec_pkg::NUM_EVT-1:0] cfg_rev;
	logic [iec_pkg::NUM_EVT*16-1:0] cfg_main;
	logic [iec_pkg::NUM_EVT*16-1:0] cfg_sub;
	logic [iec_pkg::NUM_EVT*16-1:0] cfg_hys;
	logic [31:0] mem_rdata;
	logic [iec_pkg::NUM_EVT-1:0] evt_raw;
	logic in_evt_block;
	logic [2:0] evt_index;
	logic [1:0] evt_field;
	logic setup;
	logic mem_we;

	assign setup = psel && !penable;
	assign in_evt_block = paddr[11:8] == iec_pkg::ADDR_EVT_BASE[11:8] && paddr[7:0] < 8'h50
		&& paddr[1:0] == 2'b00;
	assign evt_index = paddr[6:4];
	assign evt_field = paddr[3:2];
	assign mem_we = setup && pwrite && in_evt_block && pstrb != 4'h0;

	iec_settings_mem u_mem (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_we(mem_we),
		.i_waddr(evt_index),
		.i_wfield(evt_field),
		.i_wdata(pwdata),
		.i_raddr(evt_index),
		.i_rfield(evt_field),
		.o_rdata(mem_rdata),
		.o_type(cfg_type),
		.o_reverse(cfg_rev),
		.o_main(cfg_main),
		.o_sub(cfg_sub),
		.o_hys(cfg_hys)
	);

	genvar g;
	generate
		for (g = 0; g < iec_pkg::NUM_EVT; g++) begin : g_evt
			logic [4:0] typ;
			logic [1:0] shape;
			logic enable;
			logic signed [15:0] value;
			logic signed [15:0] ref_sp;
			logic signed [15:0] main_s;
			logic signed [15:0] sub_s;
			logic hys_ok;
			assign typ = cfg_type[g*5 +: 5];
			assign hys_ok = !cfg_hys[g*16 + 15];
			assign ref_sp = i_ramp_active ? i_final_setpoint : i_target_setpoint;
			always_comb begin
				shape = 2'd3;
				enable = 1'b1;
				value = i_process_value;
				main_s = cfg_main[g*16 +: 16];
				sub_s = cfg_sub[g*16 +: 16];
				unique case (typ)
					iec_pkg::TYPE_DEV_BAND_FINAL: begin
						shape = 2'd2;
						main_s = 16'(ref_sp + cfg_main[g*16 +: 16]);
						sub_s = 16'(ref_sp + cfg_sub[g*16 +: 16]);
					end
					iec_pkg::TYPE_SP_HIGH: begin
						shape = 2'd0;
						value = i_target_setpoint;
					end
					iec_pkg::TYPE_SP_LOW: begin
						shape = 2'd1;
						value = i_target_setpoint;
					end
					iec_pkg::TYPE_SP_BAND: begin
						shape = 2'd2;
						value = i_target_setpoint;
					end
					iec_pkg::TYPE_MV_HIGH: begin
						shape = 2'd0;
						value = i_manipulated_output;
					end
					iec_pkg::TYPE_MV_LOW: begin
						shape = 2'd1;
						value = i_manipulated_output;
					end
					iec_pkg::TYPE_MV_BAND: begin
						shape = 2'd2;
						value = i_manipulated_output;
					end
					iec_pkg::TYPE_HTR1_BAND: begin
						shape = 2'd2;
						value = state.ct1_on;
						enable = state.ct1_seen;
					end
					iec_pkg::TYPE_HTR1_SHORT: begin
						shape = 2'd0;
						value = state.ct1_off;
						enable = state.ct1_seen;
					end
					iec_pkg::TYPE_HTR2_BAND: begin
						shape = 2'd2;
						value = state.ct2_on;
						enable = state.ct2_seen;
					end
					iec_pkg::TYPE_HTR2_SHORT: begin
						shape = 2'd0;
						value = state.ct2_off;
						enable = state.ct2_seen;
					end
					default: begin
						enable = 1'b0;
					end
				endcase
			end
			iec_compare u_cmp (
				.i_clock(i_clock),
				.i_srst(i_srst),
				.i_enable(enable),
				.i_shape(shape),
				.i_reverse(cfg_rev[g]),
				.i_value(value),
				.i_main(main_s),
				.i_sub(sub_s),
				.i_hys(cfg_hys[g*16 +: 16]),
				.o_event(evt_raw[g])
			);

			// heater events held off before the first reading
			a_htr1_hold: assert property (@(posedge i_clock) disable iff (i_srst)
				(typ == iec_pkg::TYPE_HTR1_BAND || typ == iec_pkg::TYPE_HTR1_SHORT) && !state.ct1_seen
				|-> ##2 !o_event[g])
				else $error("sensor one event before first measurement");
			a_htr2_hold: assert property (@(posedge i_clock) disable iff (i_srst)
				(typ == iec_pkg::TYPE_HTR2_BAND || typ == iec_pkg::TYPE_HTR2_SHORT) && !state.ct2_seen
				|-> ##2 !o_event[g])
				else $error("sensor two event before first measurement");
			// direct limits switch on at the setting
			a_high_turn_on: assert property (@(posedge i_clock) disable iff (i_srst)
				enable && shape == 2'd0 && !cfg_rev[g] && hys_ok && value >= main_s
				|-> ##2 o_event[g])
				else $error("high limit event missing");
			a_low_turn_on: assert property (@(posedge i_clock) disable iff (i_srst)
				enable && shape == 2'd1 && !cfg_rev[g] && hys_ok && value <= main_s
				|-> ##2 o_event[g])
				else $error("low limit event missing");
			// band bounds taken in either order
			a_band_out: assert property (@(posedge i_clock) disable iff (i_srst)
				enable && shape == 2'd2 && !cfg_rev[g] && hys_ok
				&& ((value <= main_s && value <= sub_s) || (value >= main_s && value >= sub_s)) |-> ##2 o_event[g])
				else $error("band event missing");
			// Codes outside this block stay off
			a_type_off: assert property (@(posedge i_clock) disable iff (i_srst)
				typ < iec_pkg::TYPE_DEV_BAND_FINAL || typ > iec_pkg::TYPE_HTR2_SHORT
				|-> ##2 !o_event[g])
				else $error("event on for an unhandled code");
		end
	endgenerate

	always_comb begin
		next_state = state;
		next_state.evt_q = evt_raw;
		if (i_current_sensor_one_valid) begin
			next_state.ct1_seen = 1'b1;
			if (i_heater_on) begin
				next_state.ct1_on = i_current_sensor_one;
			end else begin
				next_state.ct1_off = i_current_sensor_one;
			end
		end
		if (i_current_sensor_two_valid) begin
			next_state.ct2_seen = 1'b1;
			if (i_heater_on) begin
				next_state.ct2_on = i_current_sensor_two;
			end else begin
				next_state.ct2_off = i_current_sensor_two;
			end
		end
		next_state.ready = 1'b0;
		unique case (state.bus)
			IEC_IDLE: begin
				if (setup) begin
					next_state.bus = IEC_WAIT;
					// Mask write lands on the setup edge
					if (pwrite && paddr == iec_pkg::ADDR_MASK) begin
						next_state.mask = pwdata[iec_pkg::NUM_EVT-1:0];
					end
				end
			end
			IEC_WAIT: begin
				next_state.bus = IEC_DONE;
				next_state.ready = 1'b1;
				next_state.rdata = 32'h0;
				next_state.err = 1'b0;
				// Error rises only together with pready, so pslverr is a plain flop
				if (pwrite) begin
					next_state.err = !in_evt_block && paddr != iec_pkg::ADDR_MASK && paddr != iec_pkg::ADDR_STATUS;
				end else if (paddr == iec_pkg::ADDR_STATUS) begin
					next_state.rdata = {27'h0, state.status};
				end else if (paddr == iec_pkg::ADDR_MASK) begin
					next_state.rdata = {27'h0, state.mask};
				end else if (paddr == iec_pkg::ADDR_EVENTS) begin
					next_state.rdata = {27'h0, state.evt_q};
				end else if (in_evt_block) begin
					next_state.rdata = mem_rdata;
				end else begin
					next_state.err = 1'b1;
				end
			end
			IEC_DONE: begin
				next_state.bus = IEC_IDLE;
				next_state.err = 1'b0;
				// Read clears status; new rising events win
				if (!pwrite && paddr == iec_pkg::ADDR_STATUS) begin
					next_state.status = '0;
				end
			end
			default: begin
				next_state.bus = IEC_IDLE;
			end
		endcase
		// Rising events set sticky bits after the read clear, so the set wins
		next_state.status = next_state.status | (evt_raw & ~state.evt_q);
		// Level interrupt from unmasked sticky bits
		next_state.irq = |(next_state.status & next_state.mask);
		if (i_srst) begin
			next_state = '0;
			next_state.bus = IEC_IDLE;
			next_state.mask = iec_pkg::RST_MASK;
		end
	end
	always_ff @(posedge i_clock) begin
		state <= next_state;
	end

	assign prdata = state.rdata;
	assign pready = state.ready;
	assign pslverr = state.err;
	assign o_event = state.evt_q;
	assign o_irq = state.irq;

	a_ct1_gate: assert property (@(posedge i_clock) disable iff (i_srst)
		!state.ct1_seen && cfg_type[4:0] == iec_pkg::TYPE_HTR1_BAND |-> ##2 !o_event[0])
		else $error("heater one event before measurement");
	a_ct2_gate: assert property (@(posedge i_clock) disable iff (i_srst)
		!state.ct2_seen && cfg_type[19:15] == iec_pkg::TYPE_HTR2_SHORT
		|-> ##2 !o_event[3])
		else $error("heater two event before measurement");
	a_seen_sticky: assert property (@(posedge i_clock) disable iff (i_srst)
		state.ct1_seen |=> state.ct1_seen)
		else $error("sensor one seen flag dropped");

	// Interrupt path
	a_irq_level: assert property (@(posedge i_clock) disable iff (i_srst)
		$rose(o_event[0]) && state.mask[0] |-> o_irq)
		else $error("irq not raised by unmasked event");
	a_status_set: assert property (@(posedge i_clock) disable iff (i_srst)
		$rose(o_event[0]) |-> state.status[0])
		else $error("rising event did not set status");

	// Bus protocol checks
	a_ready_pulse: assert property (@(posedge i_clock) disable iff (i_srst)
		pready |=> !pready) else $error("pready longer than one cycle");
	a_err_ready: assert property (@(posedge i_clock) disable iff (i_srst)
		pslverr |-> pready)
		else $error("pslverr outside pready");
	a_mask_write: assert property (@(posedge i_clock) disable iff (i_srst)
		setup && pwrite && paddr == iec_pkg::ADDR_MASK |=> state.mask == $past(pwdata[iec_pkg::NUM_EVT-1:0]))
		else $error("mask write lost");
	c_ready: cover property (@(posedge i_clock) disable iff (i_srst) pready && psel && penable);
	c_heater: cover property (@(posedge i_clock) disable iff (i_srst) state.ct1_seen && o_event[0]);
	c_event: cover property (@(posedge i_clock) disable iff (i_srst) o_event[0]);
	c_ramp: cover property (@(posedge i_clock) disable iff (i_srst) i_ramp_active && o_event[0]);
	c_irq: cover property (@(posedge i_clock) disable iff (i_srst) o_irq);
endmodule

/* File: tb_iec_top.sv */
// Testbench for the internal event comparator: APB register tasks and event checks.
// Assumes iec_pkg and iec_top are compiled first; one 50 MHz clock, sync reset.
`timescale 1ns/1ns
module tb_iec_top;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic o_irq;
	logic [iec_pkg::NUM_EVT-1:0] o_event;
	logic signed [15:0] pv = 16'h0000;
	logic signed [15:0] sp = 16'h0000;
	logic signed [15:0] fsp = 16'h0000;
	logic signed [15:0] mv = 16'h0000;
	logic signed [15:0] ct1 = 16'h0000;
	logic signed [15:0] ct2 = 16'h0000;
	logic ramp = 1'b0;
	logic ct1_v = 1'b0;
	logic ct2_v = 1'b0;
	logic heat = 1'b0;
	logic [31:0] rdata;
	logic rerr;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;

	always #10 i_clock = ~i_clock;

	iec_top i_dut (
		.i_clock(i_clock), .i_srst(i_srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .i_process_value(pv), .i_target_setpoint(sp), .i_final_setpoint(fsp),
		.i_ramp_active(ramp), .i_manipulated_output(mv), .i_current_sensor_one(ct1),
		.i_current_sensor_one_valid(ct1_v), .i_current_sensor_two(ct2),
		.i_current_sensor_two_valid(ct2_v), .i_heater_on(heat), .o_event(o_event), .o_irq(o_irq)
	);

	task test_done;
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			test_done();
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held from setup until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		@(posedge i_clock);
		while (pready !== 1'b1) begin
			@(posedge i_clock);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdata);
	endtask

	task cfg(input int n, input int code, input logic rev, input int m, input int s, input int h);
		logic [11:0] b;
		b = iec_pkg::ADDR_EVT_BASE + 12'(n << iec_pkg::EVT_STRIDE_SH);
		apb(1'b1, b + 12'(iec_pkg::OFS_CFG), {23'h0, rev, 3'h0, 5'(code)});
		apb(1'b1, b + 12'(iec_pkg::OFS_MAIN), {16'h0000, 16'(m)});
		apb(1'b1, b + 12'(iec_pkg::OFS_SUB), {16'h0000, 16'(s)});
		apb(1'b1, b + 12'(iec_pkg::OFS_HYS), {16'h0000, 16'(h)});
	endtask

	// Input change, then two edges of latency plus one for settling
	task drv(input int s, input int p, input int m, input int f, input logic r);
		@(posedge i_clock);
		sp <= 16'(s);
		pv <= 16'(p);
		mv <= 16'(m);
		fsp <= 16'(f);
		ramp <= r;
		repeat (3) @(posedge i_clock);
	endtask

	task pulse(input logic two, input int v, input logic h);
		@(posedge i_clock);
		heat <= h;
		if (two) begin
			ct2 <= 16'(v);
			ct2_v <= 1'b1;
		end else begin
			ct1 <= 16'(v);
			ct1_v <= 1'b1;
		end
		@(posedge i_clock);
		ct1_v <= 1'b0;
		ct2_v <= 1'b0;
		repeat (3) @(posedge i_clock);
	endtask

	task ev(input int n, input logic e, input string nm);
		chk(nm, {31'h0, e}, {31'h0, o_event[n]});
	endtask

	initial begin
		int n;
		int off;
		logic mvsrc;
		repeat (20) @(posedge i_clock);
		i_srst <= 1'b0;
		rd(iec_pkg::ADDR_MASK, 32'h0000_0000, "mask reset");
		rd(iec_pkg::ADDR_EVT_BASE, 32'h0000_0000, "cfg0 reset");
		chk("events reset", 32'h0000_0000, {27'h0, o_event});
		apb(1'b0, 12'hffc, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, rerr});
		chk("unmapped data", 32'h0000_0000, rdata);
		cfg(0, 10, 1'b0, 100, 0, 10);
		drv(100, 0, 0, 0, 1'b0);
		ev(0, 1'b1, "high at main");
		drv(91, 0, 0, 0, 1'b0);
		ev(0, 1'b1, "high in hys");
		drv(89, 0, 0, 0, 1'b0);
		ev(0, 1'b0, "high released");
		cfg(0, 10, 1'b1, 100, 0, 10);
		drv(89, 0, 0, 0, 1'b0);
		ev(0, 1'b1, "high reverse");
		for (int c = 10; c < 16; c++) begin
			n = c % 5;
			off = (c % 3 == 1) ? 99 : ((c % 3 == 2) ? 101 : 0);
			mvsrc = (c > 12);
			cfg(n, c, 1'b0, 100, -100, 0);
			drv(off, 0, off, 0, 1'b0);
			ev(n, 1'b0, "limit off");
			drv(mvsrc ? off : 100, 0, mvsrc ? 100 : off, 0, 1'b0);
			ev(n, 1'b1, "limit on");
		end
		cfg(2, 9, 1'b0, -10, 10, 0);
		drv(0, 20, 0, 200, 1'b0);
		ev(2, 1'b1, "dev band out");
		drv(0, 0, 0, 200, 1'b0);
		ev(2, 1'b0, "dev band in");
		drv(0, 0, 0, 200, 1'b1);
		ev(2, 1'b1, "ramp final out");
		drv(0, 200, 0, 200, 1'b1);
		ev(2, 1'b0, "ramp final in");
		cfg(2, 9, 1'b1, -10, 10, 0);
		drv(0, 20, 0, 200, 1'b0);
		ev(2, 1'b0, "dev reverse");
		drv(0, 0, 0, 200, 1'b1);
		ev(2, 1'b0, "ramp reverse");
		cfg(0, 16, 1'b0, 10, 100, 0);
		cfg(1, 17, 1'b1, 50, 0, 0);
		cfg(2, 18, 1'b0, 100, 10, 0);
		cfg(3, 19, 1'b1, 50, 0, 0);
		drv(0, 0, 0, 0, 1'b0);
		chk("heater idle", 32'h0000_0000, {28'h0, o_event[3:0]});
		pulse(1'b0, 5, 1'b1);
		ev(0, 1'b1, "burnout one");
		ev(1, 1'b1, "short one reverse");
		ev(2, 1'b0, "two unmeasured");
		ev(3, 1'b0, "two unmeasured rev");
		pulse(1'b1, 80, 1'b0);
		ev(2, 1'b1, "burnout two");
		ev(3, 1'b0, "short two reverse");
		pulse(1'b0, 60, 1'b0);
		ev(1, 1'b0, "short one");
		pulse(1'b1, 50, 1'b1);
		ev(2, 1'b0, "two in band");
		cfg(0, 10, 1'b0, 100, 0, 0);
		drv(0, 0, 0, 0, 1'b0);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, iec_pkg::ADDR_MASK, {31'h0, 1'(m)});
			apb(1'b0, iec_pkg::ADDR_STATUS, 32'h0000_0000);
			drv(100, 0, 0, 0, 1'b0);
			chk("irq", {31'h0, 1'(m)}, {31'h0, o_irq});
			apb(1'b0, iec_pkg::ADDR_EVENTS, 32'h0000_0000);
			chk("events live", 32'h0000_0001, {31'h0, rdata[0]});
			apb(1'b0, iec_pkg::ADDR_STATUS, 32'h0000_0000);
			chk("status set", 32'h0000_0001, {31'h0, rdata[0]});
			repeat (2) @(posedge i_clock);
			chk("irq cleared", 32'h0000_0000, {31'h0, o_irq});
			drv(0, 0, 0, 0, 1'b0);
		end
		test_done();
	end
endmodule
